// [debug_rom_table_tb_top.sv]
`timescale 1ns/10ps
module debug_rom_table_tb_top;
   import drt_pkg::*;
   logic i_clk, i_rst_b, start, present, valid, busy, done, fv, bpres_a, bpres_b, e;
   logic [31:0] fa, bp_a, bp_b, d;
   logic [3:0] cls;
   logic [FOUND_IDX_W-1:0] cnt;
   logic [31:0] found [2];
   logic done_w;
   logic [31:0] bp_c;
   logic [3:0] cls_w;
   logic [FOUND_IDX_W-1:0] cnt_w;
   int err_count, tests_run, nf;
   drt_if bus_a();
   drt_if bus_b();
   drt_if bus_c();
   drt_table drt_table_i(.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus_a), .o_base_present(bpres_a),
      .o_base_ptr(bp_a));
   drt_table #(.CLASS9(1'b1), .WIDE_ENTRIES(1'b1)) drt_table_w_i(.i_clk(i_clk), .i_rst_b(i_rst_b),
      .bus(bus_b), .o_base_present(bpres_b), .o_base_ptr(bp_b));
   drt_reader drt_reader_i(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(start), .i_base_present(present),
      .i_ptr_valid(valid), .i_base_ptr(bp_a), .i_wide(1'b0), .bus(bus_a), .o_busy(busy), .o_done(done),
      .o_found_valid(fv), .o_found_addr(fa), .o_class(cls), .o_count(cnt));
   // Wide second-class table walked by a reader in wide mode
   drt_table #(.CLASS9(1'b1), .WIDE_ENTRIES(1'b1)) drt_table_c_i(.i_clk(i_clk), .i_rst_b(i_rst_b),
      .bus(bus_c), .o_base_present(), .o_base_ptr(bp_c));
   drt_reader drt_reader_w_i(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(start), .i_base_present(present),
      .i_ptr_valid(valid), .i_base_ptr(bp_c), .i_wide(1'b1), .bus(bus_c), .o_busy(), .o_done(done_w),
      .o_found_valid(), .o_found_addr(), .o_class(cls_w), .o_count(cnt_w));
   drt_bus_sva drt_bus_sva_i(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(bus_a.req), .i_wr(bus_a.wr),
      .i_addr(bus_a.addr), .i_rdata(bus_a.rdata), .i_ack(bus_a.ack), .i_err(bus_a.err));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (fv === 1'b1) begin
         if (nf < 2) found[nf] = fa;
         nf++;
      end
   end
   task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk_bit(input logic g, input logic x);
      chk_word({31'h0, g}, {31'h0, x});
   endtask
   // One access on the second bus; request lives for one taken edge
   task automatic rd(input logic w, input logic [11:0] o, input logic [31:0] blk);
      @(posedge i_clk);
      #1;
      bus_b.req = 1'b1;
      bus_b.wr = w;
      bus_b.addr = ROM_BASE + blk + {20'h0, o};
      @(posedge i_clk);
      #1;
      bus_b.req = 1'b0;
      bus_b.addr = ~bus_b.addr;
      chk_bit(bus_b.ack, 1'b1);
      d = bus_b.rdata;
      e = bus_b.err;
   endtask
   task automatic walk(input logic p, input logic v);
      int i;
      @(posedge i_clk);
      #1;
      present = p;
      valid = v;
      start = 1'b1;
      @(posedge i_clk);
      #1;
      chk_bit(busy, p & v);
      for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge i_clk);
      #1;
      chk_bit(done, 1'b1);
   endtask
   task automatic final_report();
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   initial begin
      i_rst_b = 1'b0;
      start = 1'b0;
      present = 1'b1;
      valid = 1'b1;
      nf = 0;
      bus_b.req = 1'b0;
      bus_b.wr = 1'b0;
      bus_b.addr = 32'h0;
      bus_b.wdata = 32'hFFFFFFFF;
      repeat (12) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      chk_bit(bpres_a, 1'b1);
      chk_word(bp_a, ROM_BASE);
      chk_bit(bpres_b, 1'b1);
      chk_word(bp_b, ROM_BASE);
      walk(1'b1, 1'b1);
      chk_word({28'h0, cls}, {28'h0, CLASS_ROM1});
      chk_word({28'h0, cnt}, 32'h2);
      chk_word(nf, 2);
      chk_word(found[0], ROM_BASE + 32'h00010000);
      chk_word(found[1], ROM_BASE + 32'h00020000);
      chk_word(found[0] & 32'h0000FFFF, 32'h0);
      chk_bit(done_w, 1'b1);
      chk_word({28'h0, cls_w}, {28'h0, CLASS_ROM9});
      chk_word({28'h0, cnt_w}, 32'h2);
      start = 1'b0;
      repeat (4) @(posedge i_clk);
      walk(1'b0, 1'b1);
      chk_word(nf, 2);
      chk_word({28'h0, cnt}, 32'h0);
      start = 1'b0;
      repeat (4) @(posedge i_clk);
      walk(1'b1, 1'b0);
      chk_word(nf, 2);
      chk_word({28'h0, cnt}, 32'h0);
      start = 1'b0;
      rd(1'b0, CID1_OFS, 0);
      chk_word(d & CLASS_FIELD_MASK, {24'h0, CLASS_ROM9, 4'h0});
      rd(1'b1, CID1_OFS, 0);
      chk_word(d, 32'h0);
      rd(1'b0, CID1_OFS, 0);
      chk_word(d & CLASS_FIELD_MASK, {24'h0, CLASS_ROM9, 4'h0});
      rd(1'b0, PID4_OFS, 0);
      chk_word({28'h0, d[7:4]}, {28'h0, LEGACY_SIZE_ZERO});
      rd(1'b0, DEVICE_TYPE_VALUE_OFS, 0);
      chk_word(d, DEVICE_TYPE_VALUE_VAL);
      rd(1'b0, DEVICE_ID_VALUE_OFS, 0);
      chk_word(d, DEVICE_ID_VALUE_VAL);
      rd(1'b0, 12'h000, 0);
      chk_word(d, 32'h00010003);
      rd(1'b0, 12'h004, 0);
      chk_word(d, 32'h0);
      rd(1'b0, 12'h008, 0);
      chk_word(d, 32'h00020003);
      rd(1'b0, 12'hF00, 0);
      chk_word(d, 32'h0);
      rd(1'b0, CID3_OFS, 0);
      chk_word({24'h0, d[7:0]}, {24'h0, CID3_VAL});
      chk_bit(e, 1'b0);
      rd(1'b0, 12'h000, 32'h00001000);
      chk_bit(e, 1'b1);
      chk_word(d, 32'h0);
      final_report();
   end
endmodule // debug_rom_table_tb_top

// [drt_bus_sva.sv]
`timescale 1ns/10ps
module drt_bus_sva
   import drt_pkg::*;
#(
   parameter logic [31:0] BASE = ROM_BASE,
   parameter logic [31:0] E0 = 32'h00010003
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_rdata,
   input wire logic i_ack,
   input wire logic i_err
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   logic rd_ok;
   assign rd_ok = i_req && !i_wr && (i_addr[31:12] == BASE[31:12]);
   ack_follows_req_a: assert property (i_req |=> i_ack) else $error("ack missing after request");
   ack_has_cause_a: assert property (i_ack |-> $past(i_req)) else $error("ack without request");
   err_in_block_a: assert property (rd_ok |=> !i_err) else $error("err on in-block read");
   class_field_a: assert property (rd_ok && i_addr[11:0] == CID1_OFS |=> i_rdata[7:4] == CLASS_ROM1)
      else $error("class field wrong");
   entry_value_a: assert property (rd_ok && i_addr[11:0] == 12'h000 |=> i_rdata == E0)
      else $error("first entry wrong");
   entry_end_a: assert property (rd_ok && i_addr[11:0] == 12'h00C |=> i_rdata == ENTRY_END)
      else $error("end marker wrong");
   scan_stops_a: assert property (rd_ok && i_addr[11:0] == 12'h00C |=> !i_req [*4])
      else $error("scan went past end marker");
   rdata_hold_a: assert property (!i_req |=> $stable(i_rdata)) else $error("rdata changed without request");
   cover property (rd_ok && i_addr[11:0] == CID1_OFS);
   cover property (i_ack && i_rdata[0]);
   cover property (rd_ok && i_addr[11:0] == 12'h00C);
endmodule // drt_bus_sva

// [drt_if.sv]
`timescale 1ns/10ps
interface drt_if;
   logic req;
   logic wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic err;

   modport table_end (input req, input wr, input addr, input wdata, output rdata, output ack, output err);
   modport reader_end (output req, output wr, output addr, output wdata, input rdata, input ack, input err);
endinterface // drt_if

// [drt_pkg.sv]
package drt_pkg;
   localparam int ADDR_W = 32;
   localparam int OFS_W = 12;
   localparam int DATA_W = 32;
   localparam int BLK_SHIFT = 12;
   localparam logic [11:0] BLK_MASK = 12'hFFF;
   localparam int N_ENTRIES = 4;
   localparam int ENTRY_IDX_W = 10;
   localparam logic [11:0] ID_REGION_OFS = 12'hF00;
   localparam logic [11:0] ID_BLOCK_OFS = 12'hFD0;
   localparam logic [11:0] DEVICE_ID_VALUE_OFS = 12'hFC8;
   localparam logic [11:0] DEVICE_TYPE_VALUE_OFS = 12'hFCC;
   localparam logic [11:0] PID4_OFS = 12'hFD0;
   localparam logic [11:0] PID0_OFS = 12'hFE0;
   localparam logic [11:0] PID1_OFS = 12'hFE4;
   localparam logic [11:0] PID2_OFS = 12'hFE8;
   localparam logic [11:0] PID3_OFS = 12'hFEC;
   localparam logic [11:0] CID0_OFS = 12'hFF0;
   localparam logic [11:0] CID1_OFS = 12'hFF4;
   localparam logic [11:0] CID2_OFS = 12'hFF8;
   localparam logic [11:0] CID3_OFS = 12'hFFC;
   localparam logic [11:0] LAST_ENTRY_OFS = 12'hEFC;
   localparam int CLASS_LSB = 4;
   localparam logic [3:0] CLASS_ROM1 = 4'h1;
   localparam logic [3:0] CLASS_ROM9 = 4'h9;
   localparam logic [3:0] LEGACY_SIZE_ZERO = 4'h0;
   localparam int SIZE_LSB = 4;
   localparam logic [31:0] ENTRY_END = 32'h00000000;
   localparam logic [31:0] ENTRY_PRESENT = 32'h00000003;
   localparam logic [31:0] ENTRY_OFS_MASK = 32'hFFFFF000;
   // Arbitrary example identity values
   localparam logic [7:0] PID0_VAL = 8'h5A;
   localparam logic [7:0] PID1_VAL = 8'hA0;
   localparam logic [7:0] PID2_VAL = 8'h0B;
   localparam logic [7:0] PID3_VAL = 8'h00;
   localparam logic [3:0] PID4_LOW = 4'h0;
   localparam logic [7:0] CID0_VAL = 8'h0D;
   localparam logic [3:0] CID1_LOW = 4'h0;
   localparam logic [7:0] CID2_VAL = 8'h05;
   localparam logic [7:0] CID3_VAL = 8'hB1;
   localparam logic [31:0] DEVICE_TYPE_VALUE_VAL = 32'h00000000;
   localparam logic [31:0] DEVICE_ID_VALUE_VAL = 32'h00000000;
   localparam logic [31:0] ROM_BASE = 32'h80000000;
   localparam logic [31:0] CLASS_FIELD_MASK = 32'h000000F0;
   localparam logic [ENTRY_IDX_W-1:0] MAX_SCAN = 10'h3C0;
   localparam int FOUND_MAX = 16;
   localparam int FOUND_IDX_W = 4;
   localparam int CLASS1_SEL = 0;
   localparam int ENTRY64_SEL = 1;

   typedef enum logic [2:0] {
      DRT_IDLE, DRT_CLASS, DRT_ENTRY, DRT_ENTRY_HI, DRT_DONE
   } drt_walk_st_t;

   // Address of a component's block: table base plus the entry's offset
   function automatic logic [31:0] drt_comp_addr(input logic [31:0] base, input logic [31:0] entry);
      drt_comp_addr = base + ((entry >> BLK_SHIFT) << BLK_SHIFT);
   endfunction
endpackage

// [drt_reader.sv]
`timescale 1ns/10ps
module drt_reader
   import drt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic i_base_present,
   input wire logic i_ptr_valid,
   input wire logic [31:0] i_base_ptr,
   input wire logic i_wide,
   drt_if.reader_end bus,
   output logic o_busy,
   output logic o_done,
   output logic o_found_valid,
   output logic [31:0] o_found_addr,
   output logic [3:0] o_class,
   output logic [FOUND_IDX_W-1:0] o_count
);
   drt_walk_st_t st_ff;
   logic [31:0] base_ff;
   logic [ENTRY_IDX_W-1:0] idx_ff;
   logic req_ff;
   logic [31:0] addr_ff;
   logic found_valid_ff;
   logic [31:0] found_addr_ff;
   logic [3:0] class_ff;
   logic [FOUND_IDX_W-1:0] count_ff;
   logic [11:0] entry_ofs;
   logic [11:0] follow_ofs;

   // Byte offset of an entry; wide entries take two words each
   function automatic logic [11:0] entry_offset(input logic wide, input logic [ENTRY_IDX_W-1:0] idx);
      entry_offset = wide ? {idx[ENTRY_IDX_W-2:0], 3'b000} : {idx, 2'b00};
   endfunction

   assign entry_ofs = entry_offset(i_wide, idx_ff);
   assign follow_ofs = entry_offset(i_wide, idx_ff + 10'h001);

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         st_ff <= DRT_IDLE;
         base_ff <= 32'h00000000;
         idx_ff <= '0;
         req_ff <= 1'b0;
         addr_ff <= 32'h00000000;
         class_ff <= 4'h0;
      end else begin
         case (st_ff)
            DRT_IDLE: begin
               if (i_start) begin
                  if (!i_base_present || !i_ptr_valid) begin
                     st_ff <= DRT_DONE;
                  end else begin
                     base_ff <= i_base_ptr;
                     addr_ff <= i_base_ptr + {20'h00000, CID1_OFS};
                     req_ff <= 1'b1;
                     idx_ff <= '0;
                     st_ff <= DRT_CLASS;
                  end
               end
            end
            DRT_CLASS: begin
               req_ff <= 1'b0;
               if (bus.ack) begin
                  class_ff <= bus.rdata[CLASS_LSB +: 4];
                  addr_ff <= base_ff;
                  req_ff <= 1'b1;
                  st_ff <= DRT_ENTRY;
               end
            end
            DRT_ENTRY: begin
               req_ff <= 1'b0;
               if (bus.ack) begin
                  if (bus.rdata == ENTRY_END || idx_ff == MAX_SCAN - 10'h001
                      || entry_ofs == LAST_ENTRY_OFS || follow_ofs == ID_REGION_OFS) begin
                     st_ff <= DRT_DONE;
                  end else begin
                     idx_ff <= idx_ff + 10'h001;
                     addr_ff <= base_ff + {20'h00000, follow_ofs};
                     req_ff <= 1'b1;
                  end
               end
            end
            default: begin
               req_ff <= 1'b0;
               if (!i_start) begin
                  st_ff <= DRT_IDLE;
               end
            end
         endcase
      end
   end

   // Present entries give component block addresses; lower tables are reported for the next walk
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         found_valid_ff <= 1'b0;
         found_addr_ff <= 32'h00000000;
         count_ff <= '0;
      end else begin
         found_valid_ff <= 1'b0;
         if (st_ff == DRT_IDLE && i_start) begin
            count_ff <= '0;
         end else if (st_ff == DRT_ENTRY && bus.ack && bus.rdata != ENTRY_END
                      && bus.rdata[0]) begin
            found_valid_ff <= 1'b1;
            found_addr_ff <= drt_comp_addr(base_ff, bus.rdata);
            count_ff <= count_ff + 4'h1;
         end
      end
   end

   assign bus.req = req_ff;
   assign bus.wr = 1'b0;
   assign bus.addr = addr_ff;
   assign bus.wdata = 32'h00000000;
   assign o_busy = (st_ff != DRT_IDLE) && (st_ff != DRT_DONE);
   assign o_done = (st_ff == DRT_DONE);
   assign o_found_valid = found_valid_ff;
   assign o_found_addr = found_addr_ff;
   assign o_class = class_ff;
   assign o_count = count_ff;
endmodule // drt_reader

// [drt_table.sv]
`timescale 1ns/10ps
// Overview of operation
// - Decode exactly one 4KB block only.
// - First class reports class field 0x1.
// - Legacy block size field reads zero.
// - First class table ignores bus writes.
// - Second class reports class field 0x9.
// - Second class entries 32 or 64 bits.
// - Second class exposes device type, id.
// - Identification registers from offset 0xF00.
// - Reader computes base plus offset shifted 12.
// - Component ids start 0xFD0 above block.
// - Peripheral ids change with configuration.
// - Readers ignore legacy size field.
// - Entry points at block holding ids.
// - Entries relative; port pointer absolute.
// - Base-present zero means no components.
// - Pointer-valid zero means no components.
// - Class field in bits 7:4.
// - Reader reports lower tables, does not follow them.
// - First class assumes architecture, type zero.
// - Port base pointer targets top table.
// - Component bases aligned to 4KB granule.
// - All-zero entry ends first class list.
module drt_table
   import drt_pkg::*;
#(
   parameter logic [31:0] TABLE_BASE = ROM_BASE,
   parameter bit CLASS9 = 1'b0,
   parameter bit WIDE_ENTRIES = 1'b0,
   parameter logic [31:0] ENTRY0 = 32'h00010003,
   parameter logic [31:0] ENTRY1 = 32'h00020003,
   parameter logic [31:0] ENTRY2 = 32'h00030002,
   parameter logic [31:0] ENTRY3 = 32'h00000000,
   parameter logic [3:0] CONFIG_REV = 4'h0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   drt_if.table_end bus,
   output logic o_base_present,
   output logic [31:0] o_base_ptr
);
   logic [31:0] nxt_rdata;
   logic nxt_err;
   logic [31:0] rdata_ff;
   logic ack_ff;
   logic err_ff;
   logic [11:0] ofs;
   logic in_block;
   logic [31:0] entries [N_ENTRIES];

   // Default entries place components on 64KB boundaries
   assign entries[0] = ENTRY0;
   assign entries[1] = ENTRY1;
   assign entries[2] = ENTRY2;
   assign entries[3] = ENTRY3;

   assign ofs = bus.addr[OFS_W-1:0];
   assign in_block = ((bus.addr & ~{20'h00000, BLK_MASK}) == TABLE_BASE);

   // Absolute pointer to this top table for the port
   assign o_base_present = 1'b1;
   assign o_base_ptr = TABLE_BASE;

   always_comb begin
      int idx;
      idx = 0;
      nxt_rdata = 32'h00000000;
      nxt_err = 1'b0;
      if (!in_block) begin
         nxt_err = 1'b1;
      end else if (bus.wr) begin
         nxt_rdata = 32'h00000000;
      end else if (ofs < ID_REGION_OFS) begin
         idx = int'(ofs >> 2);
         if (CLASS9 && WIDE_ENTRIES) begin
            // 64-bit entries: low word then upper word
            if (idx / 2 < N_ENTRIES) begin
               nxt_rdata = (idx % 2 == 0) ? entries[idx / 2] : 32'h00000000;
            end
         end else if (idx < N_ENTRIES) begin
            nxt_rdata = entries[idx];
         end
      end else if (ofs == DEVICE_ID_VALUE_OFS) begin
         nxt_rdata = CLASS9 ? DEVICE_ID_VALUE_VAL : 32'h00000000;
      end else if (ofs == DEVICE_TYPE_VALUE_OFS) begin
         nxt_rdata = CLASS9 ? DEVICE_TYPE_VALUE_VAL : 32'h00000000;
      end else if (ofs == PID4_OFS) begin
         nxt_rdata = {24'h000000, LEGACY_SIZE_ZERO, PID4_LOW};
      end else if (ofs == PID0_OFS) begin
         nxt_rdata = {24'h000000, PID0_VAL};
      end else if (ofs == PID1_OFS) begin
         nxt_rdata = {24'h000000, PID1_VAL};
      end else if (ofs == PID2_OFS) begin
         nxt_rdata = {24'h000000, PID2_VAL};
      end else if (ofs == PID3_OFS) begin
         nxt_rdata = {24'h000000, CONFIG_REV, PID3_VAL[3:0]};
      end else if (ofs == CID0_OFS) begin
         nxt_rdata = {24'h000000, CID0_VAL};
      end else if (ofs == CID1_OFS) begin
         nxt_rdata = {24'h000000, (CLASS9 ? CLASS_ROM9 : CLASS_ROM1), CID1_LOW};
      end else if (ofs == CID2_OFS) begin
         nxt_rdata = {24'h000000, CID2_VAL};
      end else if (ofs == CID3_OFS) begin
         nxt_rdata = {24'h000000, CID3_VAL};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus.req;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         rdata_ff <= 32'h00000000;
         err_ff <= 1'b0;
      end else if (bus.req) begin
         rdata_ff <= nxt_rdata;
         err_ff <= nxt_err;
      end
   end

   assign bus.rdata = rdata_ff;
   assign bus.ack = ack_ff;
   assign bus.err = err_ff;
endmodule // drt_table
